// ---- usb_ep_fifo_reset_bytecount.sv ----
/*
  Endpoint FIFO reset control and per-endpoint received byte count, as an
  AXI4-Lite slave. Assumes the packet engine reports each received packet
  count with a one-cycle strobe on clk, and the FIFOs honour the clear levels.
*/
// The AXI4-Lite register port was left to the implementer.
//
// Contract
// [RL1] Count bits 10..8 of selected endpoint appear in high register bits 2..0.
// [RL2] High register follows the endpoint select field, not a fixed endpoint.
// [RL3] Reserved high register bits read zero; software writes no ones there.
// [RL4] Reset register has one FIFO clear bit per endpoint 0..6; bit 7 reserved.
// [RL5] Firmware sets each clear bit first after hardware or bus reset.
// [RL6] FIFO stays cleared while its bit is set; clearing it frees the FIFO.
// [RL7] Low register gives count bits 7..0; count is bytes after data PID.
// [RL8] High register is read-only; writes neither store nor disturb counts.
`timescale 1ns/1ps
module usb_ep_fifo_reset_bytecount
   import usb_epctl_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic                              ce,
   // AXI4-Lite write
   input  wire logic [usb_epctl_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [31:0]                       s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic [1:0]                             s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [usb_epctl_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic [31:0]                            s_axi_rdata,
   output logic [1:0]                             s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   // Packet engine: received count strobe
   input  wire logic                              rx_done,
   input  wire logic [usb_epctl_pkg::EPSEL_W-1:0] rx_ep,
   input  wire logic [usb_epctl_pkg::COUNT_W-1:0] rx_count,
   // FIFO clear levels, one per endpoint
   output logic [usb_epctl_pkg::NUM_EP-1:0]       fifo_clear
);
   import usb_epctl_pkg::*;

   typedef struct packed {
      logic                           awready;
      logic                           wready;
      logic                           aw_held;
      logic [ADDR_W-1:0]              aw_addr;
      logic                           w_held;
      logic [31:0]                    w_data;
      logic [3:0]                     w_strb;
      logic                           bvalid;
      logic [1:0]                     bresp;
      logic                           arready;
      logic                           rvalid;
      logic [31:0]                    rdata;
      logic [1:0]                     rresp;
      logic [NUM_EP-1:0]              fifo_rst;
      logic [EPSEL_W-1:0]             ep_sel;
      logic [NUM_EP-1:0][COUNT_W-1:0] count;
   } state_t;

   state_t st;
   state_t next_st;

   // ------------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------------
   // Returns register content and whether the address is mapped
   function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] a,
                                              input state_t s);
      logic [COUNT_W-1:0] c;
      c = '0;
      // Select value 7 names no endpoint: read a zero count, not an X
      if (s.ep_sel < EPSEL_W'(NUM_EP)) begin
         c = s.count[s.ep_sel];                                    // RL2
      end
      if (a == ADDR_FIFO_RESET) begin
         read_word = {1'b1, 24'h0, 1'b0, s.fifo_rst};             // RL4
      end else if (a == ADDR_COUNT_HIGH) begin
         read_word = {1'b1, 29'h0, c[COUNT_W-1:COUNT_HIGH_LSB]};  // RL1 RL3
      end else if (a == ADDR_COUNT_LOW) begin
         read_word = {1'b1, 24'h0, c[COUNT_HIGH_LSB-1:0]};        // RL7
      end else if (a == ADDR_ENDPOINT_SEL) begin
         read_word = {1'b1, 29'h0, s.ep_sel};
      end else begin
         read_word = {1'b0, 32'h0};
      end
   endfunction : read_word

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Address and data accepted in either order; response after both
   always_comb begin
      logic [32:0] rw;
      logic        do_wr;
      rw = 33'h0;
      do_wr = 1'b0;
      next_st = st;
      if (s_axi_awvalid && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
         next_st.awready = 1'b0;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
         next_st.wready = 1'b0;
      end
      // Packet count capture precedes writes, which never touch counts
      if (rx_done && rx_ep < EPSEL_W'(NUM_EP)) begin
         next_st.count[rx_ep] = rx_count;                          // RL7
      end
      do_wr = st.aw_held && st.w_held && !st.bvalid;
      if (do_wr) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         if (st.aw_addr == ADDR_FIFO_RESET) begin
            if (st.w_strb[0]) begin
               // Reserved bit 7 dropped so it always reads zero
               next_st.fifo_rst = st.w_data[NUM_EP-1:0];            // RL4 RL6
            end
         end else if (st.aw_addr == ADDR_ENDPOINT_SEL) begin
            if (st.w_strb[0]) begin
               next_st.ep_sel = st.w_data[EPSEL_W-1:0];
            end
         end else if (st.aw_addr == ADDR_COUNT_HIGH || st.aw_addr == ADDR_COUNT_LOW) begin
            next_st.bresp = RESP_OKAY;                              // RL8
         end else begin
            next_st.bresp = RESP_SLVERR;
         end
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid  = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
      end
      // Read: one cycle after address taken
      if (s_axi_arvalid && st.arready) begin
         rw = read_word(s_axi_araddr, st);
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rdata   = rw[31:0];
         next_st.rresp   = rw[32] ? RESP_OKAY : RESP_SLVERR;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid  = 1'b0;
         next_st.arready = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Synchronous reset; ce low freezes everything
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st          <= '0;
         st.awready  <= 1'b1;
         st.wready   <= 1'b1;
         st.arready  <= 1'b1;
         st.fifo_rst <= FIFO_RESET_RST[NUM_EP-1:0];
         st.ep_sel   <= EPSEL_RST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign fifo_clear    = st.fifo_rst;                              // RL6

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence rd_high_taken;
      ce && s_axi_arvalid && st.arready && s_axi_araddr == ADDR_COUNT_HIGH;
   endsequence

   a_high_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      rd_high_taken |=> s_axi_rvalid && s_axi_rdata[31:3] == 29'h0)      // RL3
      else $error("count high reserved bits not zero");

   a_high_selected_ep: assert property (@(posedge clk) disable iff (!rst_n)
      rd_high_taken |=> s_axi_rdata[2:0] ==
         $past(st.count[st.ep_sel][COUNT_W-1:COUNT_HIGH_LSB]))           // RL1 RL2
      else $error("count high shows wrong endpoint bits");

   a_low_selected_ep: assert property (@(posedge clk) disable iff (!rst_n)
      ce && s_axi_arvalid && st.arready && s_axi_araddr == ADDR_COUNT_LOW
      |=> s_axi_rdata == {24'h0, $past(st.count[st.ep_sel][7:0])})      // RL7
      else $error("count low wrong");

   a_reset_bit7_zero: assert property (@(posedge clk) disable iff (!rst_n)
      ce && s_axi_arvalid && st.arready && s_axi_araddr == ADDR_FIFO_RESET
      |=> s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[6:0] == $past(fifo_clear)) // RL4
      else $error("fifo reset readback wrong");

   a_clear_held: assert property (@(posedge clk) disable iff (!rst_n)
      !(st.aw_held && st.w_held && st.aw_addr == ADDR_FIFO_RESET) || !ce
      |=> $stable(fifo_clear))                                           // RL6
      else $error("fifo clear changed without write");

   a_clear_written: assert property (@(posedge clk) disable iff (!rst_n)
      ce && st.aw_held && st.w_held && !st.bvalid && st.w_strb[0]
         && st.aw_addr == ADDR_FIFO_RESET
      |=> fifo_clear == $past(st.w_data[6:0]) ##0 s_axi_bvalid)          // RL6
      else $error("fifo clear write lost");

   a_high_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      ce && st.aw_held && st.w_held && !st.bvalid && !rx_done
         && st.aw_addr == ADDR_COUNT_HIGH
      |=> st.count == $past(st.count))                                   // RL8
      else $error("write disturbed counts");

   a_count_captured: assert property (@(posedge clk) disable iff (!rst_n)
      ce && rx_done && rx_ep == 3'h2 |=> st.count[2] == $past(rx_count)) // RL7
      else $error("count not captured");

endmodule : usb_ep_fifo_reset_bytecount

// ---- usb_epctl_pkg.sv ----
/*
  Package for the endpoint FIFO reset and byte count high block: register
  offsets, field positions, reset values and widths.
  Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
*/
package usb_epctl_pkg;
   // Printed offsets are not multiples of four: they are indices
   localparam logic [7:0]  IDX_FIFO_RESET     = 8'hD5;
   localparam logic [7:0]  IDX_COUNT_HIGH     = 8'hE3;
   localparam logic [7:0]  IDX_COUNT_LOW      = 8'hE2;
   localparam logic [7:0]  IDX_ENDPOINT_SEL   = 8'hC7;
   localparam int          ADDR_W             = 12;
   localparam logic [11:0] ADDR_FIFO_RESET    = {2'h0, IDX_FIFO_RESET, 2'h0};
   localparam logic [11:0] ADDR_COUNT_HIGH    = {2'h0, IDX_COUNT_HIGH, 2'h0};
   localparam logic [11:0] ADDR_COUNT_LOW     = {2'h0, IDX_COUNT_LOW, 2'h0};
   localparam logic [11:0] ADDR_ENDPOINT_SEL  = {2'h0, IDX_ENDPOINT_SEL, 2'h0};
   // Field layout
   localparam int          NUM_EP             = 7;
   localparam int          EPSEL_W            = 3;
   localparam int          COUNT_W            = 11;
   localparam int          COUNT_HIGH_LSB     = 8;
   localparam logic [7:0]  FIFO_RESET_MASK    = 8'h7F;
   // Reset values
   localparam logic [7:0]  FIFO_RESET_RST     = 8'h00;
   localparam logic [7:0]  COUNT_HIGH_RST     = 8'h00;
   localparam logic [2:0]  EPSEL_RST          = 3'h0;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;
endpackage : usb_epctl_pkg

// ---- usb_ep_fifo_reset_bytecount_tb_top.sv ----
/*
  Self-checking bench for the endpoint FIFO reset and byte count block.
  Assumes the package constants and a single 125 MHz clock domain.
*/
`timescale 1ns/1ps
module usb_ep_fifo_reset_bytecount_tb_top;
   import usb_epctl_pkg::*;
   // ----------------------------------------
   // Stimulus and observation signals
   // ----------------------------------------
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                ce = 1'b1;
   logic [ADDR_W-1:0]   awaddr = '0, araddr = '0;
   logic [31:0]         wdata = '0, rdata;
   logic [3:0]          wstrb = 4'hF;
   logic                awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [1:0]          bresp, rresp;
   logic                rx_done = 0;
   logic [EPSEL_W-1:0]  rx_ep = '0;
   logic [COUNT_W-1:0]  rx_count = '0;
   logic [NUM_EP-1:0]   fifo_clear;
   int                  errors = 0, num_checks = 0;
   logic [31:0]         rd;
   logic [1:0]          rs;
   logic [COUNT_W-1:0]  exp_cnt;

   always #4 clk = ~clk;

   usb_ep_fifo_reset_bytecount u_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_done(rx_done),
      .rx_ep(rx_ep), .rx_count(rx_count), .fifo_clear(fifo_clear));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic close_out();
      if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Hang guard: a lost handshake ends the run with a mismatch
   task automatic give_up(input string name);
      errors++;
      $display("CHECK FAILED %s expected handshake seen none", name);
      close_out();
   endtask : give_up

   // Address and data offered together, each released when taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 100) give_up("write");
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 100) give_up("read");
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] e);
      axi_rd(a, rd, rs);
      chk(name, e, rd);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
   endtask : rd_chk

   // Count for endpoint n puts n in the upper bits, patterns 0 to 6, bit 10 included
   function automatic logic [10:0] cnt_of(input int n);
      return {n[2:0], 8'hA5 ^ n[7:0]};
   endfunction : cnt_of

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      chk("clear_rst", 32'h0, {25'h0, fifo_clear});
      rd_chk("rst_ctl", ADDR_FIFO_RESET, {24'h0, FIFO_RESET_RST});
      rd_chk("cnt_high_rst", ADDR_COUNT_HIGH, {24'h0, COUNT_HIGH_RST});
      // Each endpoint bit drives its own FIFO clear; reserved bit dropped
      for (int n = 0; n < 8; n++) begin
         axi_wr(ADDR_FIFO_RESET, 32'h1 << n, RESP_OKAY);
         #1 chk("clear_bit", {25'h0, 7'(32'h1 << n)}, {25'h0, fifo_clear});
         rd_chk("ctl_bit", ADDR_FIFO_RESET, (32'h1 << n) & 32'h7F);
      end
      axi_wr(ADDR_FIFO_RESET, 32'hFF, RESP_OKAY);
      #1 chk("clear_all", 32'h7F, {25'h0, fifo_clear});
      axi_wr(ADDR_FIFO_RESET, 32'h00, RESP_OKAY);
      #1 chk("clear_none", 32'h0, {25'h0, fifo_clear});
      // Back-to-back packet strobes, one per endpoint
      for (int n = 0; n < NUM_EP; n++) begin
         @(posedge clk);
         rx_done <= 1'b1; rx_ep <= 3'(n); rx_count <= cnt_of(n);
      end
      @(posedge clk);
      rx_done <= 1'b0;
      // High register follows the select field across all endpoints
      for (int n = NUM_EP - 1; n >= 0; n--) begin
         exp_cnt = cnt_of(n);
         axi_wr(ADDR_ENDPOINT_SEL, n, RESP_OKAY);
         rd_chk("cnt_high", ADDR_COUNT_HIGH, {29'h0, exp_cnt[10:8]});
         rd_chk("cnt_low", ADDR_COUNT_LOW, {24'h0, exp_cnt[7:0]});
      end
      // Writes to the counts are accepted but change nothing; no reserved ones
      axi_wr(ADDR_COUNT_HIGH, 32'h03, RESP_OKAY);
      axi_wr(ADDR_COUNT_LOW, 32'h00, RESP_OKAY);
      rd_chk("cnt_high_ro", ADDR_COUNT_HIGH, {29'h0, exp_cnt[10:8]});
      rd_chk("cnt_low_ro", ADDR_COUNT_LOW, {24'h0, exp_cnt[7:0]});
      // Enable low freezes state: a strobe seen while frozen is lost
      @(posedge clk);
      ce <= 1'b0;
      rx_done <= 1'b1;
      rx_ep <= 3'h0;
      rx_count <= 11'h7FF;
      repeat (2) @(posedge clk);
      rx_done <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      rd_chk("cnt_low_frozen", ADDR_COUNT_LOW, {24'h0, exp_cnt[7:0]});
      rd_chk("cnt_high_frozen", ADDR_COUNT_HIGH, {29'h0, exp_cnt[10:8]});
      // Unmapped address refused on both channels
      axi_wr(12'h004, 32'h1, RESP_SLVERR);
      axi_rd(12'h004, rd, rs);
      chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      chk("unmapped_rdata", 32'h0, rd);
      rd_chk("ctl_kept", ADDR_FIFO_RESET, 32'h0);
      // Mid-run reset returns control, select and counts to zero
      axi_wr(ADDR_FIFO_RESET, 32'h55, RESP_OKAY);
      axi_wr(ADDR_ENDPOINT_SEL, 32'h3, RESP_OKAY);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk("clear_rerst", 32'h0, {25'h0, fifo_clear});
      axi_wr(ADDR_FIFO_RESET, 32'h7F, RESP_OKAY);
      #1 chk("clear_rerst_all", 32'h7F, {25'h0, fifo_clear});
      rd_chk("sel_rerst", ADDR_ENDPOINT_SEL, 32'h0);
      rd_chk("cnt_high_rerst", ADDR_COUNT_HIGH, {24'h0, COUNT_HIGH_RST});
      rd_chk("cnt_low_rerst", ADDR_COUNT_LOW, 32'h0);
      close_out();
   end
endmodule : usb_ep_fifo_reset_bytecount_tb_top
